//--- design/tlc_tension_core.sv
// Loss compensation, stall operation and monitor output of the tension drive
//
// Overview of operation
// - Up to five frequency/loss break points accepted
// - Loss and bias decode as setting minus 500
// - Linear interpolation between neighbouring break points
// - Compensation saturated at plus/minus one hundred percent
// - No points and nonzero bias: bias alone
// - Unwinding subtracts compensation, winding adds it
// - Break points ordered by ascending frequency
// - Equal frequencies: lowest index wins, others dropped
// - Any zero hertz point discards the bias
// - Frequency 0-400 Hz, 9999 reserved, losses reset 500
// - Stall plus start ramps limit to stall setting
// - Stall torque is command times stall scale
// - Inertia inputs cancel stall, restore normal values
// - Stall request forces loss compensation off
// - Stall reasserted while running reapplies stall behaviour
// - Pre-excite, DC brake, forced stop override stall
// - Start removed during stall ramps speed to zero
// - Monitor codes 63/64/65: tension, loss, inertia
// - Monitor values offset by plus 500 percent
// - Tension control disabled: monitor reports zero
// - Accel input adds, decel subtracts, both cancel
module tlc_tension_core
  import tlc_pkg::*;
#(
  parameter int RAMP_UNIT_CYCLES = RAMP_UNIT_CYC
)(
  input  wire logic                clk_sys_i,
  input  wire logic                rstn_i,
  input  wire logic                start_i,
  input  wire logic                stall_request_i,
  input  wire logic                accel_inertia_comp_in_i,
  input  wire logic                decel_inertia_comp_in_i,
  input  wire logic                pre_excite_input_i,
  input  wire logic                dc_brake_input_i,
  input  wire logic                forced_stop_i,
  input  wire logic                param_load_i,
  input  wire logic [15:0]         loss_point_freq_i [NUM_PTS],
  input  wire logic [9:0]          loss_point_loss_i [NUM_PTS],
  input  wire logic [9:0]          loss_bias_setting_i,
  input  wire logic                wind_direction_select_i,
  input  wire logic [11:0]         stall_torque_scale_i,
  input  wire logic [15:0]         stall_speed_limit_i,
  input  wire logic [19:0]         stall_ramp_time_i,
  input  wire logic [15:0]         ramp_ref_freq_i,
  input  wire logic [15:0]         normal_speed_limit_i,
  input  wire logic [15:0]         op_freq_i,
  input  wire logic signed [15:0]  torque_cmd_i,
  input  wire logic [15:0]         inertia_torque_i,
  input  wire logic [7:0]          monitor_selector_i,
  input  wire logic                tension_enable_i,
  output logic signed [15:0]       tension_cmd_o,
  output logic signed [15:0]       torque_out_o,
  output logic signed [15:0]       loss_comp_o,
  output logic [15:0]              speed_limit_o,
  output logic [15:0]              monitor_o,
  output logic                     stall_active_o
);
  typedef enum logic [1:0] {CV_SCAN = 2'b01, CV_WAIT = 2'b10} tlc_cv_state_t;

  function automatic logic signed [15:0] dec_loss(input logic [9:0] v);
    logic signed [15:0] d;
    d = $signed({6'h00, v}) - $signed({6'h00, LOSS_ZERO});
    return 16'(d * PCT_TO_TENTH);
  endfunction

  function automatic logic signed [15:0] sat(input logic signed [16:0] v,
                                             input logic signed [16:0] lim);
    if (v > lim)
      return 16'(lim);
    else if (v < -lim)
      return 16'(-lim);
    else
      return 16'(v);
  endfunction

  tlc_div_if #(.NW(DIV_NW), .DW(DIV_DW)) div_bus ();

  logic [SYNC_W-1:0] s1, s2, s3, filt, next_filt, pins;
  logic [15:0]       pf [NUM_PTS];
  logic [15:0]       next_pf [NUM_PTS];
  logic [9:0]        pl [NUM_PTS];
  logic [9:0]        next_pl [NUM_PTS];
  logic [9:0]        bias, next_bias;
  logic [11:0]       scale, next_scale;
  logic [15:0]       slim, next_slim;
  logic [19:0]       rtime, next_rtime;
  logic [NUM_PTS-1:0] pt_valid, pt_zero, pt_use;
  logic              lo_ok, hi_ok;
  logic [2:0]        lo_idx, hi_idx;
  tlc_cv_state_t     cv_state, next_cv_state;
  logic signed [15:0] base, next_base, comp, next_comp, curve;
  logic              neg, next_neg, div_go;
  logic signed [15:0] l_lo, l_hi, l_diff;
  logic [15:0]       l_mag;
  logic signed [15:0] tension, torque, loss_used, inertia, monitor_val;
  logic signed [15:0] next_tension, next_torque, next_loss_o, next_mon_s;
  logic [15:0]       monitor, next_monitor, spd, next_spd, spd_target;
  logic              stall_on, next_stall_on, stall_req, cancel, overr;
  logic [ACC_W-1:0]  acc, next_acc, acc_sum, ramp_thr;
  logic signed [28:0] scaled;

  assign pins = {forced_stop_i, dc_brake_input_i, pre_excite_input_i,
                 decel_inertia_comp_in_i, accel_inertia_comp_in_i,
                 stall_request_i, start_i};
  // A pin change counts only once the last two stages agree
  assign next_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);

  always_comb begin
    next_pf    = pf;
    next_pl    = pl;
    next_bias  = bias;
    next_scale = scale;
    next_slim  = slim;
    next_rtime = rtime;
    if (param_load_i) begin
      for (int i = 0; i < NUM_PTS; i++) begin
        // Out of range codes saturate rather than being rejected
        if (loss_point_freq_i[i] != FREQ_UNUSED && loss_point_freq_i[i] > FREQ_MAX)
          next_pf[i] = FREQ_MAX;
        else
          next_pf[i] = loss_point_freq_i[i];
        if (loss_point_loss_i[i] < LOSS_MIN)
          next_pl[i] = LOSS_MIN;
        else if (loss_point_loss_i[i] > LOSS_MAX)
          next_pl[i] = LOSS_MAX;
        else
          next_pl[i] = loss_point_loss_i[i];
      end
      next_bias  = (loss_bias_setting_i < LOSS_MIN) ? LOSS_MIN :
                   (loss_bias_setting_i > LOSS_MAX) ? LOSS_MAX : loss_bias_setting_i;
      next_scale = (stall_torque_scale_i > STALL_TQ_MAX) ? STALL_TQ_MAX
                                                         : stall_torque_scale_i;
      next_slim  = (stall_speed_limit_i > STALL_SPD_MAX) ? STALL_SPD_MAX
                                                         : stall_speed_limit_i;
      next_rtime = stall_ramp_time_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PTS; g++) begin : gen_pt
      assign pt_valid[g] = (pf[g] != FREQ_UNUSED);
      assign pt_zero[g]  = (pf[g] == 16'h0000);
    end
  endgenerate

  // Neighbour search stands in for a sort: same result, no sort network
  always_comb begin
    pt_use = pt_valid;
    lo_ok  = 1'b0;
    hi_ok  = 1'b0;
    lo_idx = 3'h0;
    hi_idx = 3'h0;
    for (int i = 1; i < NUM_PTS; i++)
      for (int j = 0; j < i; j++)
        if (pt_valid[j] && pf[j] == pf[i])
          pt_use[i] = 1'b0;
    for (int i = 0; i < NUM_PTS; i++) begin
      if (pt_use[i]) begin
        if (pf[i] <= op_freq_i) begin
          if (!lo_ok || pf[i] > pf[lo_idx]) begin
            lo_ok  = 1'b1;
            lo_idx = 3'(i);
          end
        end else if (!hi_ok || pf[i] < pf[hi_idx]) begin
          hi_ok  = 1'b1;
          hi_idx = 3'(i);
        end
      end
    end
  end

  assign l_lo   = dec_loss(pl[lo_idx]);
  assign l_hi   = dec_loss(pl[hi_idx]);
  assign l_diff = l_hi - l_lo;
  assign l_mag  = l_diff[15] ? 16'(-l_diff) : 16'(l_diff);
  assign div_go = (cv_state == CV_SCAN) && lo_ok && hi_ok;
  assign div_bus.start = div_go;
  assign div_bus.num   = DIV_NW'(32'(op_freq_i - pf[lo_idx]) * 32'(l_mag));
  assign div_bus.den   = pf[hi_idx] - pf[lo_idx];

  always_comb begin
    next_cv_state = cv_state;
    next_base     = base;
    next_neg      = neg;
    next_comp     = comp;
    curve         = 16'sh0000;
    case (cv_state)
      CV_SCAN: begin
        if (div_go) begin
          next_base     = l_lo;
          next_neg      = l_diff[15];
          next_cv_state = CV_WAIT;
        end else begin
          // Outside the configured span the end point value is held
          curve     = lo_ok ? l_lo : (hi_ok ? l_hi : 16'sh0000);
          next_comp = sat(17'(curve) + 17'(|pt_zero ? 16'sh0000 : dec_loss(bias)),
                          COMP_LIM);
        end
      end
      CV_WAIT: begin
        if (div_bus.done) begin
          curve         = neg ? base - 16'(div_bus.quot) : base + 16'(div_bus.quot);
          next_comp     = sat(17'(curve) + 17'(|pt_zero ? 16'sh0000 : dec_loss(bias)),
                              COMP_LIM);
          next_cv_state = CV_SCAN;
        end
      end
      default: next_cv_state = CV_SCAN;
    endcase
  end

  tlc_divider u_div (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .div       (div_bus.slave)
  );

  assign stall_req = filt[IN_STALL];
  assign cancel    = filt[IN_ACCEL] | filt[IN_DECEL];
  assign overr     = filt[IN_PREEX] | filt[IN_DCBRK] | filt[IN_FSTOP];

  always_comb begin
    next_stall_on = stall_req && !cancel && !overr;
    loss_used     = stall_req ? 16'sh0000 : comp;
    if (filt[IN_ACCEL] && !filt[IN_DECEL])
      inertia = $signed(inertia_torque_i);
    else if (filt[IN_DECEL] && !filt[IN_ACCEL])
      inertia = -$signed(inertia_torque_i);
    else
      inertia = 16'sh0000;
    if (wind_direction_select_i)
      next_tension = sat(17'(torque_cmd_i) - 17'(loss_used), WORD_LIM);
    else
      next_tension = sat(17'(torque_cmd_i) + 17'(loss_used), WORD_LIM);
    scaled = 29'(torque_cmd_i) * $signed({17'h00000, scale}) / SCALE_UNITY;
    if (next_stall_on)
      next_torque = sat(17'(scaled), WORD_LIM);
    else
      next_torque = sat(17'(next_tension) + 17'(inertia), WORD_LIM);
    next_loss_o = loss_used;
  end

  // Rate accumulator: one 0.01 Hz step whenever ramp time worth of reference builds up
  assign spd_target = filt[IN_START] ? slim : 16'h0000;
  assign ramp_thr   = ACC_W'(rtime) * ACC_W'(RAMP_UNIT_CYCLES);
  assign acc_sum    = acc + ACC_W'(ramp_ref_freq_i);

  always_comb begin
    next_spd = spd;
    next_acc = '0;
    if (!next_stall_on) begin
      next_spd = normal_speed_limit_i;
    end else if (rtime == 20'h00000) begin
      next_spd = spd_target;
    end else if (spd != spd_target) begin
      next_acc = acc_sum;
      if (acc_sum >= ramp_thr) begin
        next_acc = acc_sum - ramp_thr;
        next_spd = (spd < spd_target) ? spd + 16'h0001 : spd - 16'h0001;
      end
    end
  end

  always_comb begin
    case (monitor_selector_i)
      MON_TENSION: monitor_val = tension;
      MON_LOSS:    monitor_val = loss_used;
      MON_INERTIA: monitor_val = inertia;
      default:     monitor_val = 16'sh0000;
    endcase
    next_mon_s   = sat(17'(monitor_val), MON_LIM) + MON_OFS;
    next_monitor = (tension_enable_i && (monitor_selector_i == MON_TENSION ||
                    monitor_selector_i == MON_LOSS || monitor_selector_i == MON_INERTIA))
                   ? next_mon_s : 16'h0000;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      s1       <= '0;
      s2       <= '0;
      s3       <= '0;
      filt     <= '0;
      for (int i = 0; i < NUM_PTS; i++) begin
        pf[i] <= FREQ_UNUSED;
        pl[i] <= LOSS_ZERO;
      end
      bias     <= LOSS_ZERO;
      scale    <= STALL_TQ_RST;
      slim     <= STALL_SPD_RST;
      rtime    <= RAMP_TIME_RST;
      cv_state <= CV_SCAN;
      base     <= 16'sh0000;
      neg      <= 1'b0;
      comp     <= 16'sh0000;
      tension  <= 16'sh0000;
      torque   <= 16'sh0000;
      loss_comp_o <= 16'sh0000;
      monitor  <= 16'h0000;
      spd      <= 16'h0000;
      acc      <= '0;
      stall_on <= 1'b0;
    end else begin
      s1       <= pins;
      s2       <= s1;
      s3       <= s2;
      filt     <= next_filt;
      pf       <= next_pf;
      pl       <= next_pl;
      bias     <= next_bias;
      scale    <= next_scale;
      slim     <= next_slim;
      rtime    <= next_rtime;
      cv_state <= next_cv_state;
      base     <= next_base;
      neg      <= next_neg;
      comp     <= next_comp;
      tension  <= next_tension;
      torque   <= next_torque;
      loss_comp_o <= next_loss_o;
      monitor  <= next_monitor;
      spd      <= next_spd;
      acc      <= next_acc;
      stall_on <= next_stall_on;
    end
  end

  assign tension_cmd_o  = tension;
  assign torque_out_o   = torque;
  assign monitor_o      = monitor;
  assign speed_limit_o  = spd;
  assign stall_active_o = stall_on;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  sequence seq_stall_held;
    stall_req && !cancel && !overr;
  endsequence

  chk_comp_clamp: assert property (comp <= 16'sh03E8 && comp >= -16'sh03E8)
    else $error("loss compensation left its clamp range");
  chk_stall_noloss: assert property (stall_req |=> loss_comp_o == 16'sh0000)
    else $error("loss compensation active during stall request");
  chk_stall_cancel: assert property (stall_req && cancel |=> !stall_active_o)
    else $error("inertia input did not cancel stall");
  chk_stall_override: assert property (overr |=> !stall_active_o)
    else $error("override input did not beat stall");
  chk_stall_torque: assert property (seq_stall_held |=>
    torque_out_o == sat(17'($past(scaled)), WORD_LIM))
    else $error("stall torque not scaled command");
  chk_wind_dir: assert property (!stall_req && !wind_direction_select_i |=>
    tension_cmd_o == sat(17'($past(torque_cmd_i)) + 17'($past(comp)), WORD_LIM))
    else $error("winding tension not command plus loss");
  chk_ramp_step: assert property (seq_stall_held ##1
    (stall_req && !cancel && !overr && rtime != 20'h00000) |=>
    (spd - $past(spd) == 16'h0001) || ($past(spd) - spd == 16'h0001) || spd == $past(spd))
    else $error("stall speed limit jumped");
  chk_monitor_off: assert property (!tension_enable_i |=> monitor_o == 16'h0000)
    else $error("monitor not zero while disabled");
  chk_monitor_loss: assert property (tension_enable_i && monitor_selector_i == MON_LOSS
    |=> monitor_o == 16'($past(sat(17'(loss_used), MON_LIM)) + MON_OFS))
    else $error("loss monitor value wrong");
  chk_bias_only: assert property (cv_state == CV_SCAN && pt_valid == '0 |=>
    comp == $past(dec_loss(bias)))
    else $error("bias alone not used without break points");
endmodule

//--- pkg/tlc_pkg.sv
// Shared constants for the tension loss compensation and stall block
package tlc_pkg;
  localparam int              NUM_PTS        = 5;
  localparam int              SYNC_W         = 7;
  localparam int              IN_START       = 0;
  localparam int              IN_STALL       = 1;
  localparam int              IN_ACCEL       = 2;
  localparam int              IN_DECEL       = 3;
  localparam int              IN_PREEX       = 4;
  localparam int              IN_DCBRK       = 5;
  localparam int              IN_FSTOP       = 6;
  localparam logic [15:0]     FREQ_UNUSED    = 16'h270F;
  localparam logic [15:0]     FREQ_MAX       = 16'h9C40;
  localparam logic [9:0]      LOSS_ZERO      = 10'h1F4;
  localparam logic [9:0]      LOSS_MIN       = 10'h190;
  localparam logic [9:0]      LOSS_MAX       = 10'h258;
  localparam logic signed [15:0] PCT_TO_TENTH = 16'sh000A;
  localparam logic signed [16:0] COMP_LIM    = 17'sh003E8;
  localparam logic signed [16:0] MON_LIM     = 17'sh00FA0;
  localparam logic signed [16:0] WORD_LIM    = 17'sh07FFF;
  localparam logic signed [15:0] MON_OFS     = 16'sh1388;
  localparam logic signed [28:0] SCALE_UNITY = 29'sh00003E8;
  localparam logic [11:0]     STALL_TQ_RST   = 12'h0C8;
  localparam logic [11:0]     STALL_TQ_MAX   = 12'h7D0;
  localparam logic [15:0]     STALL_SPD_RST  = 16'h0064;
  localparam logic [15:0]     STALL_SPD_MAX  = 16'h1770;
  localparam logic [19:0]     RAMP_TIME_RST  = 20'h005DC;
  localparam logic [7:0]      MON_TENSION    = 8'h3F;
  localparam logic [7:0]      MON_LOSS       = 8'h40;
  localparam logic [7:0]      MON_INERTIA    = 8'h41;
  localparam int              CLK_PERIOD_NS  = 50;
  localparam int              RAMP_UNIT_NS   = 10000000;
  localparam int              RAMP_UNIT_CYC  = RAMP_UNIT_NS / CLK_PERIOD_NS;
  localparam int              DIV_NW         = 28;
  localparam int              DIV_DW         = 16;
  localparam int              DIV_CNT_W      = 5;
  localparam int              ACC_W          = 48;
endpackage

//--- pkg/tlc_div_if.sv
// Handshake between the loss curve logic and its serial divider
interface tlc_div_if #(
  parameter int NW = 28,
  parameter int DW = 16
);
  logic          start;
  logic [NW-1:0] num;
  logic [DW-1:0] den;
  logic          done;
  logic [NW-1:0] quot;
  modport master (output start, output num, output den, input done, input quot);
  modport slave  (input start, input num, input den, output done, output quot);
endinterface

//--- design/tlc_divider.sv
// Serial restoring divider used for break point interpolation
module tlc_divider
  import tlc_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  tlc_div_if.slave  div
);
  typedef enum logic [1:0] {DV_IDLE = 2'b01, DV_RUN = 2'b10} tlc_dv_state_t;

  tlc_dv_state_t          state;
  tlc_dv_state_t          next_state;
  logic [DIV_DW:0]        rem;
  logic [DIV_DW:0]        next_rem;
  logic [DIV_NW-1:0]      quo;
  logic [DIV_NW-1:0]      next_quo;
  logic [DIV_DW-1:0]      den;
  logic [DIV_DW-1:0]      next_den;
  logic [DIV_CNT_W-1:0]   cnt;
  logic [DIV_CNT_W-1:0]   next_cnt;
  logic                   done;
  logic                   next_done;
  logic [DIV_DW:0]        trial;

  always_comb begin
    next_state = state;
    next_rem   = rem;
    next_quo   = quo;
    next_den   = den;
    next_cnt   = cnt;
    next_done  = 1'b0;
    trial      = {rem[DIV_DW-1:0], quo[DIV_NW-1]};
    case (state)
      DV_IDLE: begin
        if (div.start) begin
          next_rem   = '0;
          next_quo   = div.num;
          next_den   = div.den;
          next_cnt   = DIV_CNT_W'(DIV_NW - 1);
          next_state = DV_RUN;
        end
      end
      DV_RUN: begin
        // One quotient bit per clock keeps the datapath narrow
        if (trial >= {1'b0, den}) begin
          next_rem = trial - {1'b0, den};
          next_quo = {quo[DIV_NW-2:0], 1'b1};
        end else begin
          next_rem = trial;
          next_quo = {quo[DIV_NW-2:0], 1'b0};
        end
        next_cnt = cnt - 1'b1;
        if (cnt == '0) begin
          next_done  = 1'b1;
          next_state = DV_IDLE;
        end
      end
      default: next_state = DV_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state <= DV_IDLE;
      rem   <= '0;
      quo   <= '0;
      den   <= '0;
      cnt   <= '0;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      rem   <= next_rem;
      quo   <= next_quo;
      den   <= next_den;
      cnt   <= next_cnt;
      done  <= next_done;
    end
  end

  assign div.done = done;
  assign div.quot = quo;

  sequence seq_div_launch;
    div.start && state == DV_IDLE;
  endsequence

  chk_div_finish: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    seq_div_launch |-> ##[28:29] done)
    else $error("divider did not finish in time");
endmodule

//--- tb/tlc_partner.sv
// Far-side controller model that drives the start and auxiliary pins
module tlc_partner (
  input  wire logic       clk_sys_i,
  input  wire logic [6:0] cmd_i,
  output logic      [6:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin_o = 7'h00;
  // Levels only move just after an edge and are held until told otherwise
  always @(posedge clk_sys_i) begin
    pin_o <= cmd_i;
  end
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the tension loss compensation core
module tb_top
  import tlc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] VECS [7] = '{7'h02, 7'h06, 7'h0E, 7'h02, 7'h12, 7'h22, 7'h42};
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               load = 1'b0;
  logic               wdir = 1'b0;
  logic               ten_en = 1'b1;
  logic [6:0]         cmd = 7'h00;
  logic [6:0]         pin;
  logic [15:0]        freq [NUM_PTS];
  logic [9:0]         loss [NUM_PTS];
  logic [9:0]         bias = LOSS_ZERO;
  logic [11:0]        scale = STALL_TQ_RST;
  logic [15:0]        slim = STALL_SPD_RST;
  logic [19:0]        ramp = 20'h00001;
  logic [15:0]        nlim = 16'h0008;
  logic [15:0]        op_f = 16'h0000;
  logic [15:0]        iner = 16'h0064;
  logic signed [15:0] torque = 16'sh0000;
  logic [7:0]         sel = MON_TENSION;
  logic signed [15:0] ten_o, tq_o, comp_o;
  logic [15:0]        spd_o, mon_o;
  logic               stall_o;
  logic [31:0]        lfsr = 32'hBAA0;
  int                 num_errors = 0;
  int                 num_checks = 0;

  tlc_partner PTN (.clk_sys_i(clk), .cmd_i(cmd), .pin_o(pin));

  // Short ramp unit keeps the stall ramp within a few cycles
  tlc_tension_core #(.RAMP_UNIT_CYCLES(4)) DUT (
    .clk_sys_i              (clk),
    .rstn_i                 (rst_n),
    .start_i                (pin[IN_START]),
    .stall_request_i        (pin[IN_STALL]),
    .accel_inertia_comp_in_i(pin[IN_ACCEL]),
    .decel_inertia_comp_in_i(pin[IN_DECEL]),
    .pre_excite_input_i     (pin[IN_PREEX]),
    .dc_brake_input_i       (pin[IN_DCBRK]),
    .forced_stop_i          (pin[IN_FSTOP]),
    .param_load_i           (load),
    .loss_point_freq_i      (freq),
    .loss_point_loss_i      (loss),
    .loss_bias_setting_i    (bias),
    .wind_direction_select_i(wdir),
    .stall_torque_scale_i   (scale),
    .stall_speed_limit_i    (slim),
    .stall_ramp_time_i      (ramp),
    .ramp_ref_freq_i        (16'h0004),
    .normal_speed_limit_i   (nlim),
    .op_freq_i              (op_f),
    .torque_cmd_i           (torque),
    .inertia_torque_i       (iner),
    .monitor_selector_i     (sel),
    .tension_enable_i       (ten_en),
    .tension_cmd_o          (ten_o),
    .torque_out_o           (tq_o),
    .loss_comp_o            (comp_o),
    .speed_limit_o          (spd_o),
    .monitor_o              (mon_o),
    .stall_active_o         (stall_o)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Long wait covers the worst-case serial divide
  task automatic apply();
    @(posedge clk);
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    cyc(70);
    #1;
  endtask

  // Pins pass a synchroniser and filter, so allow well over six edges
  task automatic pins(input logic [6:0] v);
    @(posedge clk);
    cmd <= v;
    cyc(10);
    #1;
  endtask

  task automatic wait_spd(input logic [15:0] v);
    for (int n = 0; n < 300 && spd_o !== v; n++) begin
      @(posedge clk);
      #1;
    end
  endtask

  function automatic logic [31:0] next_rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // Reference curve: first point of a frequency wins, ends hold outside the span
  function automatic int model_comp();
    int pf[$];
    int pl[$];
    int c = 0;
    int lo = -1;
    int hi = -1;
    bit zero = 1'b0;
    for (int i = 0; i < NUM_PTS; i++) begin
      zero |= freq[i] == 16'h0000;
      if (freq[i] != FREQ_UNUSED && !(int'(freq[i]) inside {pf})) begin
        pf.push_back(int'(freq[i]));
        pl.push_back((int'(loss[i]) - 500) * 10);
      end
    end
    foreach (pf[k]) begin
      if (pf[k] <= int'(op_f) && (lo < 0 || pf[k] > pf[lo])) lo = k;
      if (pf[k] > int'(op_f) && (hi < 0 || pf[k] < pf[hi])) hi = k;
    end
    if (lo >= 0 && hi >= 0) c = pl[lo] + (pl[hi] - pl[lo]) * (int'(op_f) - pf[lo])
                                / (pf[hi] - pf[lo]);
    else if (lo >= 0) c = pl[lo];
    else if (hi >= 0) c = pl[hi];
    if (!zero) c += (int'(bias) - 500) * 10;
    return c > 1000 ? 1000 : (c < -1000 ? -1000 : c);
  endfunction

  task automatic check_norm();
    int c;
    int t;
    c = model_comp();
    t = wdir ? torque - c : torque + c;
    check("loss_comp", comp_o, 16'(c));
    check("tension", ten_o, 16'(t));
    check("torque_out", tq_o, 16'(t));
    check("speed_limit", spd_o, nlim);
    check("monitor", mon_o, 16'(t + 5000));
  endtask

  initial begin
    int t;
    int v;
    int tqs[4];
    foreach (freq[i]) begin
      freq[i] = FREQ_UNUSED;
      loss[i] = LOSS_ZERO;
    end
    cyc(4);
    rst_n <= 1'b1;
    cyc(40);
    #1;
    check_norm();
    $display("test reset done");
    for (int w = 0; w < 2; w++) begin
      @(posedge clk);
      bias <= 10'h226;
      wdir <= w[0];
      torque <= 16'(int'(next_rnd() % 2048) - 1024);
      apply();
      check_norm();
    end
    $display("test bias done");
    @(posedge clk);
    freq <= '{16'h0BB8, 16'h03E8, 16'h0BB8, FREQ_UNUSED, 16'h07D0};
    loss <= '{LOSS_MAX, LOSS_MIN, 10'h1C2, LOSS_ZERO, LOSS_ZERO};
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      op_f <= k < 4 ? 16'(500 + 1000 * k) : 16'(next_rnd() % 4000);
      apply();
      check_norm();
    end
    @(posedge clk);
    freq[3] <= 16'h0000;
    op_f <= 16'h01F4;
    apply();
    check_norm();
    $display("test curve done");
    t = wdir ? torque - model_comp() : torque + model_comp();
    for (int j = 0; j < 8; j++) begin
      @(posedge clk);
      sel <= j[1:0] == 2'b11 ? 8'h10 : 8'(63 + j[1:0]);
      ten_en <= ~j[2];
      cyc(4);
      #1;
      v = j[1:0] == 2'b00 ? t : (j[1:0] == 2'b01 ? model_comp() : 0);
      check("monitor", mon_o, (!j[2] && j[1:0] != 2'b11) ? 16'(v + 5000) : 16'h0000);
    end
    $display("test monitor done");
    @(posedge clk);
    sel <= MON_TENSION;
    ten_en <= 1'b1;
    foreach (freq[i]) freq[i] <= FREQ_UNUSED;
    bias <= LOSS_ZERO;
    scale <= 12'h5DC;
    slim <= 16'h000C;
    torque <= 16'(int'(next_rnd() % 2048) - 1024);
    apply();
    tqs = '{torque * 1500 / 1000, torque + 100, torque, torque * 1500 / 1000};
    for (int k = 0; k < 7; k++) begin
      pins(VECS[k]);
      check("stall_active", {15'h0000, stall_o}, {15'h0000, k == 0 || k == 3});
      if (k < 4) check("torque_out", tq_o, 16'(tqs[k]));
      if (k == 0) check("loss_comp", comp_o, 16'h0000);
    end
    $display("test stall done");
    pins(7'h03);
    wait_spd(16'h000C);
    check("speed_limit", spd_o, 16'h000C);
    pins(7'h02);
    wait_spd(16'h0000);
    check("speed_limit", spd_o, 16'h0000);
    pins(7'h00);
    $display("test ramp done");
    end_sim();
  end

  initial begin
    cyc(10000);
    num_errors++;
    end_sim();
  end
endmodule
